/* File: hdl/pwmifc_gen.sv */
`timescale 1ns/10ps
`include "pwmifc_map.svh"

module pwmifc_gen
	import pwmifc_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic [3:0] cmp_evt,
	input wire logic inten_wr,
	input wire logic isc_wr,
	input wire logic per_wr,
	input wire logic [31:0] wdata,
	output pwmifc_evt_t irq_en,
	output pwmifc_evt_t trig_en,
	output pwmifc_evt_t raw_status,
	output pwmifc_evt_t masked_status,
	output pwmifc_per_t period_prog,
	output logic gen_irq_pend,
	output logic gen_trig
);

	// ******************************************************
	// time base: zero pulses one period apart
	// ******************************************************
	pwmifc_per_t cnt_ff, nxt_cnt, active_ff, nxt_active, prog_ff;
	logic pending_ff;
	pwmifc_evt_t ien_ff, ten_ff, ris_ff;
	logic trig_ff;
	wire at_zero = run && (cnt_ff == `PWMIFC_RST_PERIOD);
	// a pending update takes effect at the zero event only
	wire pwmifc_per_t load_val = pending_ff ? prog_ff : active_ff;
	wire pwmifc_evt_t evt_now = {cmp_evt[3], cmp_evt[2], cmp_evt[1], cmp_evt[0], at_zero, at_zero};

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_active = active_ff;
		if (at_zero) begin
			nxt_active = load_val;
			nxt_cnt = (load_val == `PWMIFC_RST_PERIOD) ? load_val : load_val - 16'h0001;
		end else if (run) begin
			nxt_cnt = cnt_ff - 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff <= `PWMIFC_RST_PERIOD;
			active_ff <= `PWMIFC_RST_PERIOD;
		end else begin
			cnt_ff <= nxt_cnt;
			active_ff <= nxt_active;
		end
	end

	// latest write simply overwrites the staged value
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prog_ff <= `PWMIFC_RST_PERIOD;
			pending_ff <= 1'b0;
		end else begin
			if (per_wr) begin
				prog_ff <= wdata[15:0];
			end
			pending_ff <= per_wr | (pending_ff & ~at_zero);
		end
	end

	// ******************************************************
	// enables and status
	// ******************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ien_ff <= 6'h00;
			ten_ff <= 6'h00;
		end else if (inten_wr) begin
			ien_ff <= wdata[`PWMIFC_INTEN_IRQ_LSB +: 6];
			ten_ff <= wdata[`PWMIFC_INTEN_TRIG_LSB +: 6];
		end
	end

	// set wins over a write-one clear in the same cycle
	wire pwmifc_evt_t clr_mask = isc_wr ? wdata[5:0] : 6'h00;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ris_ff <= 6'h00;
			trig_ff <= 1'b0;
		end else begin
			ris_ff <= (ris_ff & ~clr_mask) | evt_now;
			trig_ff <= |(evt_now & ten_ff);
		end
	end

	assign irq_en = ien_ff;
	assign trig_en = ten_ff;
	assign raw_status = ris_ff;
	assign masked_status = ris_ff & ien_ff;
	assign gen_irq_pend = |(ris_ff & ien_ff);
	assign period_prog = prog_ff;
	assign gen_trig = trig_ff;

endmodule : pwmifc_gen

/* File: hdl/pwmifc_map.svh */
`ifndef PWMIFC_MAP_SVH
`define PWMIFC_MAP_SVH

// ******************************************************
// register offsets (byte addresses, one word each; the generator word offsets are word indices)
// ******************************************************
`define PWMIFC_OFS_CTRL 8'h00
`define PWMIFC_OFS_MOD_INTEN 8'h04
`define PWMIFC_OFS_MOD_RIS 8'h08
`define PWMIFC_OFS_MOD_ISC 8'h0C
`define PWMIFC_OFS_SUPPRESS 8'h10
`define PWMIFC_OFS_FLEVEL 8'h14
`define PWMIFC_OFS_FSENSE 8'h18
`define PWMIFC_OFS_FSEL 8'h1C
`define PWMIFC_OFS_GEN_BASE 8'h40
`define PWMIFC_GEN_STRIDE 8'h10
`define PWMIFC_GOFS_INTEN 2'h0
`define PWMIFC_GOFS_RIS 2'h1
`define PWMIFC_GOFS_ISC 2'h2
`define PWMIFC_GOFS_PERIOD 2'h3

// ******************************************************
// field positions and widths
// ******************************************************
`define PWMIFC_NGEN 4
`define PWMIFC_NFLT 4
`define PWMIFC_NOUT 8
`define PWMIFC_NEVT 6
`define PWMIFC_PER_W 16
`define PWMIFC_CTRL_RUN_LSB 0
`define PWMIFC_CTRL_EXT_LSB 4
`define PWMIFC_INTEN_IRQ_LSB 0
`define PWMIFC_INTEN_TRIG_LSB 8
`define PWMIFC_MOD_GEN_LSB 0
`define PWMIFC_MOD_FLT_LSB 4

// ******************************************************
// reset values
// ******************************************************
`define PWMIFC_RST_PERIOD 16'h0000
`define PWMIFC_RST_BYTE 8'h00
`define PWMIFC_RST_FSEL 16'h1111

`endif

/* File: hdl/pwmifc_pkg.sv */
package pwmifc_pkg;

	typedef logic [5:0] pwmifc_evt_t;
	typedef logic [15:0] pwmifc_per_t;
	typedef logic [7:0] pwmifc_byte_t;

	typedef enum logic [2:0] {
		PWMIFC_EVT_ZERO = 3'h0,
		PWMIFC_EVT_RELOAD = 3'h1,
		PWMIFC_EVT_A_UP = 3'h2,
		PWMIFC_EVT_A_DOWN = 3'h3,
		PWMIFC_EVT_B_UP = 3'h4,
		PWMIFC_EVT_B_DOWN = 3'h5
	} pwmifc_evt_idx_t;

endpackage : pwmifc_pkg

/* File: hdl/pwmifc_top.sv */
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "pwmifc_map.svh"

// Functional notes
// - each generator has an enable register whose set bits pass the chosen sources to its interrupt or trigger.
// - the enable register holds six interrupt and six trigger sources: zero, reload, A up/down, B up/down.
// - cleared enable bits mask their sources so they no longer raise the generator interrupt or trigger.
// - each generator offers a raw status of all events and a masked status of enabled events only.
// - module raw and masked status hold one summary bit per generator and one bit per fault input.
// - a module enable register unmasks or masks the four generator and four fault interrupts.
// - a generator interrupt leaves only when its source, module and controller enables are all set.
// - the period value is the count of clock ticks between successive zero events of the generator.
// - reading a period returns the last written value even while the update is still pending.
// - repeated period writes before the update keep only the newest value.
// - each of eight outputs has a suppress bit forcing it inactive during a fault, otherwise untouched.
// - without extended fault handling or a configured level, suppressed outputs go low in a fault.
// - with extended fault handling the fault level of each suppressed output is configurable.
// - software clears generator status bits by writing ones; zero bits stay as they are.
// - in extended mode a generator fault is the OR of its selected fault inputs after sense adjustment.
module pwmifc_top
	import pwmifc_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [15:0] cmp_evt,
	input wire logic [3:0] fault_pin,
	input wire logic [7:0] pwm_raw,
	output logic [7:0] pwm_out,
	output logic [3:0] gen_irq,
	output logic [3:0] gen_trig,
	output logic irq
);

	// ******************************************************
	// address decode
	// ******************************************************
	wire sel_ctrl = (reg_addr == `PWMIFC_OFS_CTRL);
	wire sel_mod_inten = (reg_addr == `PWMIFC_OFS_MOD_INTEN);
	wire sel_mod_ris = (reg_addr == `PWMIFC_OFS_MOD_RIS);
	wire sel_mod_isc = (reg_addr == `PWMIFC_OFS_MOD_ISC);
	wire sel_supp = (reg_addr == `PWMIFC_OFS_SUPPRESS);
	wire sel_flevel = (reg_addr == `PWMIFC_OFS_FLEVEL);
	wire sel_fsense = (reg_addr == `PWMIFC_OFS_FSENSE);
	wire sel_fsel = (reg_addr == `PWMIFC_OFS_FSEL);

	// generator window: base 0x40, four blocks of four words
	wire in_gen_win = (reg_addr[7:6] == 2'h1) && (reg_addr[1:0] == 2'h0);
	wire [1:0] gen_idx = reg_addr[5:4];
	wire [1:0] gen_word = reg_addr[3:2];

	// ******************************************************
	// module-level registers
	// ******************************************************
	logic [7:0] ctrl_ff;
	logic [7:0] mod_inten_ff;
	logic [7:0] supp_ff;
	logic [7:0] flevel_ff;
	logic [3:0] fsense_ff;
	logic [15:0] fsel_ff;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_ff <= `PWMIFC_RST_BYTE;
			mod_inten_ff <= `PWMIFC_RST_BYTE;
			supp_ff <= `PWMIFC_RST_BYTE;
			flevel_ff <= `PWMIFC_RST_BYTE;
			fsense_ff <= 4'h0;
			fsel_ff <= `PWMIFC_RST_FSEL;
		end else if (reg_wr) begin
			if (sel_ctrl) begin
				ctrl_ff <= reg_wdata[7:0];
			end
			if (sel_mod_inten) begin
				mod_inten_ff <= reg_wdata[7:0];
			end
			if (sel_supp) begin
				supp_ff <= reg_wdata[7:0];
			end
			if (sel_flevel) begin
				flevel_ff <= reg_wdata[7:0];
			end
			if (sel_fsense) begin
				fsense_ff <= reg_wdata[3:0];
			end
			if (sel_fsel) begin
				fsel_ff <= reg_wdata[15:0];
			end
		end
	end

	wire [3:0] gen_run = ctrl_ff[`PWMIFC_CTRL_RUN_LSB +: 4];
	wire [3:0] gen_ext = ctrl_ff[`PWMIFC_CTRL_EXT_LSB +: 4];

	// ******************************************************
	// generators
	// ******************************************************
	pwmifc_evt_t g_ien [4];
	pwmifc_evt_t g_ten [4];
	pwmifc_evt_t g_ris [4];
	pwmifc_evt_t g_mis [4];
	pwmifc_per_t g_per [4];
	logic [3:0] g_pend;
	logic [3:0] g_trig;

	// one decode per word, shared by all four generators
	wire gen_wr = reg_wr && in_gen_win;
	wire wr_inten = gen_wr && (gen_word == `PWMIFC_GOFS_INTEN);
	wire wr_isc = gen_wr && (gen_word == `PWMIFC_GOFS_ISC);
	wire wr_per = gen_wr && (gen_word == `PWMIFC_GOFS_PERIOD);
	wire [3:0] gen_hit = 4'h1 << gen_idx;

	// ******************************************************
	// generator instances
	// ******************************************************
	// generator g owns cmp_evt[4g+3:4g]
	pwmifc_gen u_gen0 (
		.clk(clk),
		.reset_n(reset_n),
		.run(gen_run[0]),
		.cmp_evt(cmp_evt[3:0]),
		.inten_wr(wr_inten && gen_hit[0]),
		.isc_wr(wr_isc && gen_hit[0]),
		.per_wr(wr_per && gen_hit[0]),
		.wdata(reg_wdata),
		.irq_en(g_ien[0]),
		.trig_en(g_ten[0]),
		.raw_status(g_ris[0]),
		.masked_status(g_mis[0]),
		.period_prog(g_per[0]),
		.gen_irq_pend(g_pend[0]),
		.gen_trig(g_trig[0])
	);

	pwmifc_gen u_gen1 (
		.clk(clk),
		.reset_n(reset_n),
		.run(gen_run[1]),
		.cmp_evt(cmp_evt[7:4]),
		.inten_wr(wr_inten && gen_hit[1]),
		.isc_wr(wr_isc && gen_hit[1]),
		.per_wr(wr_per && gen_hit[1]),
		.wdata(reg_wdata),
		.irq_en(g_ien[1]),
		.trig_en(g_ten[1]),
		.raw_status(g_ris[1]),
		.masked_status(g_mis[1]),
		.period_prog(g_per[1]),
		.gen_irq_pend(g_pend[1]),
		.gen_trig(g_trig[1])
	);

	pwmifc_gen u_gen2 (
		.clk(clk),
		.reset_n(reset_n),
		.run(gen_run[2]),
		.cmp_evt(cmp_evt[11:8]),
		.inten_wr(wr_inten && gen_hit[2]),
		.isc_wr(wr_isc && gen_hit[2]),
		.per_wr(wr_per && gen_hit[2]),
		.wdata(reg_wdata),
		.irq_en(g_ien[2]),
		.trig_en(g_ten[2]),
		.raw_status(g_ris[2]),
		.masked_status(g_mis[2]),
		.period_prog(g_per[2]),
		.gen_irq_pend(g_pend[2]),
		.gen_trig(g_trig[2])
	);

	pwmifc_gen u_gen3 (
		.clk(clk),
		.reset_n(reset_n),
		.run(gen_run[3]),
		.cmp_evt(cmp_evt[15:12]),
		.inten_wr(wr_inten && gen_hit[3]),
		.isc_wr(wr_isc && gen_hit[3]),
		.per_wr(wr_per && gen_hit[3]),
		.wdata(reg_wdata),
		.irq_en(g_ien[3]),
		.trig_en(g_ten[3]),
		.raw_status(g_ris[3]),
		.masked_status(g_mis[3]),
		.period_prog(g_per[3]),
		.gen_irq_pend(g_pend[3]),
		.gen_trig(g_trig[3])
	);

	// ******************************************************
	// fault inputs
	// ******************************************************
	// pins are asynchronous: two stages before any logic looks at them
	logic [3:0] fault_meta_ff;
	logic [3:0] fault_sync_ff;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fault_meta_ff <= 4'h0;
			fault_sync_ff <= 4'h0;
		end else begin
			fault_meta_ff <= fault_pin;
			fault_sync_ff <= fault_meta_ff;
		end
	end

	// sense bit set means the input is asserted while low
	wire [3:0] fault_act = fault_sync_ff ^ fsense_ff;

	logic [3:0] gen_fault;
	always_comb begin
		for (int g = 0; g < `PWMIFC_NGEN; g++) begin
			if (gen_ext[g]) begin
				gen_fault[g] = |(fsel_ff[4*g +: 4] & fault_act);
			end else begin
				gen_fault[g] = fault_act[0];
			end
		end
	end

	// ******************************************************
	// module status and interrupt
	// ******************************************************
	logic [3:0] flt_sts_ff;
	wire mod_isc_wr = reg_wr && sel_mod_isc;
	wire [3:0] flt_clr = mod_isc_wr ? reg_wdata[`PWMIFC_MOD_FLT_LSB +: 4] : 4'h0;

	// a fault that is still present re-sets its bit, even under a clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flt_sts_ff <= 4'h0;
		end else begin
			flt_sts_ff <= (flt_sts_ff & ~flt_clr) | fault_act;
		end
	end

	// generator bits summarise the generator, cleared at the generator itself
	wire [7:0] mod_raw = {flt_sts_ff, g_pend};
	wire [7:0] mod_masked = mod_raw & mod_inten_ff;

	logic [3:0] gen_irq_ff;
	logic [3:0] gen_trig_ff;
	logic irq_ff;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gen_irq_ff <= 4'h0;
			gen_trig_ff <= 4'h0;
			irq_ff <= 1'b0;
		end else begin
			gen_irq_ff <= g_pend & mod_inten_ff[`PWMIFC_MOD_GEN_LSB +: 4];
			gen_trig_ff <= g_trig;
			irq_ff <= |mod_masked;
		end
	end

	assign gen_irq = gen_irq_ff;
	assign gen_trig = gen_trig_ff;
	assign irq = irq_ff;

	// ******************************************************
	// output fault suppression
	// ******************************************************
	// outputs 2g and 2g+1 belong to generator g
	logic [7:0] nxt_pwm;
	always_comb begin
		for (int o = 0; o < `PWMIFC_NOUT; o++) begin
			if (gen_fault[o / 2] && supp_ff[o]) begin
				// level only honoured in extended mode; default level is low
				nxt_pwm[o] = gen_ext[o / 2] & flevel_ff[o];
			end else begin
				nxt_pwm[o] = pwm_raw[o];
			end
		end
	end

	logic [7:0] pwm_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pwm_ff <= 8'h00;
		end else begin
			pwm_ff <= nxt_pwm;
		end
	end

	assign pwm_out = pwm_ff;

	// ******************************************************
	// read path
	// ******************************************************
	// unmapped addresses read zero; reads have no side effects
	logic [31:0] gen_rd;
	always_comb begin
		case (gen_word)
			`PWMIFC_GOFS_INTEN: gen_rd = {18'h00000, g_ten[gen_idx], 2'h0, g_ien[gen_idx]};
			`PWMIFC_GOFS_RIS: gen_rd = {26'h0000000, g_ris[gen_idx]};
			`PWMIFC_GOFS_ISC: gen_rd = {26'h0000000, g_mis[gen_idx]};
			`PWMIFC_GOFS_PERIOD: gen_rd = {16'h0000, g_per[gen_idx]};
			default: gen_rd = 32'h00000000;
		endcase
	end

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		if (sel_ctrl) begin
			rd_mux = {24'h000000, ctrl_ff};
		end else if (sel_mod_inten) begin
			rd_mux = {24'h000000, mod_inten_ff};
		end else if (sel_mod_ris) begin
			rd_mux = {24'h000000, mod_raw};
		end else if (sel_mod_isc) begin
			rd_mux = {24'h000000, mod_masked};
		end else if (sel_supp) begin
			rd_mux = {24'h000000, supp_ff};
		end else if (sel_flevel) begin
			rd_mux = {24'h000000, flevel_ff};
		end else if (sel_fsense) begin
			rd_mux = {28'h0000000, fsense_ff};
		end else if (sel_fsel) begin
			rd_mux = {16'h0000, fsel_ff};
		end else if (in_gen_win) begin
			rd_mux = gen_rd;
		end
	end

	// data stands only in the cycle after the strobe
	logic [31:0] rdata_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= 32'h00000000;
		end else begin
			rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule : pwmifc_top

/* File: tb/pwmifc_intc_model.sv */
`timescale 1ns/10ps
// ****************
// interrupt controller model
// ****************
module pwmifc_intc_model (
	input wire logic [3:0] gen_irq,
	input wire logic irq,
	input wire logic [4:0] line_en,
	output logic cpu_irq
);
	// a line reaches the processor only while its controller enable is set
	assign cpu_irq = |(gen_irq & line_en[3:0]) | (irq & line_en[4]);
endmodule : pwmifc_intc_model

/* File: tb/pwmifc_properties.sv */
`timescale 1ns/10ps
// ****************
// port checker
// ****************
module pwmifc_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [15:0] cmp_evt,
	input wire logic [3:0] fault_pin,
	input wire logic [7:0] pwm_raw,
	input wire logic [7:0] pwm_out,
	input wire logic [3:0] gen_irq,
	input wire logic [3:0] gen_trig,
	input wire logic irq
);
	logic [7:0] sup_ff;
	logic [7:0] ctl_ff;
	logic [7:0] men_ff;
	logic [5:0] ten_ff [4];
	logic [3:0] ten_any;
	logic live_ff;
	// shadows follow software writes, so no hierarchical peeking is needed
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			live_ff <= 1'b0;
			sup_ff <= 8'h00;
			ctl_ff <= 8'h00;
			men_ff <= 8'h00;
			for (int g = 0; g < 4; g++) ten_ff[g] <= 6'h00;
		end else begin
			live_ff <= 1'b1;
			if (reg_wr && reg_addr == 8'h10) sup_ff <= reg_wdata[7:0];
			if (reg_wr && reg_addr == 8'h00) ctl_ff <= reg_wdata[7:0];
			if (reg_wr && reg_addr == 8'h04) men_ff <= reg_wdata[7:0];
			for (int g = 0; g < 4; g++) if (reg_wr && reg_addr == {2'h1, g[1:0], 4'h0}) ten_ff[g] <= reg_wdata[13:8];
		end
	end
	always_comb for (int g = 0; g < 4; g++) ten_any[g] = |ten_ff[g];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_rdata_quiet: assert property (live_ff && !$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data seen without a read");
	a_out_pass: assert property (live_ff |-> ((~$past(sup_ff)) & (pwm_out ^ $past(pwm_raw))) == 8'h00)
		else $error("unsuppressed output altered");
	a_fault_low: assert property (live_ff && $past(ctl_ff[7:4]) == 4'h0 |-> (pwm_out & ~$past(pwm_raw)) == 8'h00)
		else $error("output driven high by a fault");
	a_gen_irq_gate: assert property ((gen_irq & ~$past(men_ff[3:0])) == 4'h0)
		else $error("generator interrupt while module enable clear");
	a_irq_summary: assert property (|gen_irq |-> irq)
		else $error("module interrupt missing its generator summary");
	a_irq_gate: assert property (irq |-> $past(men_ff) != 8'h00)
		else $error("module interrupt with all enables clear");
	a_trig_gate: assert property ((gen_trig & ~$past(ten_any, 2)) == 4'h0)
		else $error("trigger from a masked generator");
	a_trig_event: assert property (cmp_evt[0] && ten_ff[0][2] |-> ##2 gen_trig[0])
		else $error("enabled event gave no trigger");
	cover property (gen_irq != 4'h0);
	cover property (irq);
	cover property ($past(sup_ff) != 8'h00 && pwm_out != $past(pwm_raw));
endmodule : pwmifc_checker

bind pwmifc_top pwmifc_checker chk_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_evt(cmp_evt), .fault_pin(fault_pin),
	.pwm_raw(pwm_raw), .pwm_out(pwm_out), .gen_irq(gen_irq), .gen_trig(gen_trig), .irq(irq));

/* File: tb/pwmifc_top_tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin mismatches++; $display("FAIL %s exp %h got %h", n, e, a); end end
module pwmifc_top_tb;
	logic clk, reset_n, reg_wr, reg_rd, irq, cpu_irq, rnd_raw;
	logic [7:0] reg_addr, pwm_raw, pwm_out, ga;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [15:0] cmp_evt;
	logic [3:0] fault_pin, gen_irq, gen_trig;
	logic [4:0] intc_en;
	logic [5:0] en;
	int mismatches, num_checks, seed, n;
	pwmifc_top dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_evt(cmp_evt), .fault_pin(fault_pin), .pwm_raw(pwm_raw),
		.pwm_out(pwm_out), .gen_irq(gen_irq), .gen_trig(gen_trig), .irq(irq));
	pwmifc_intc_model intc_u (.gen_irq(gen_irq), .irq(irq), .line_en(intc_en), .cpu_irq(cpu_irq));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (rnd_raw) pwm_raw <= 8'($random(seed));
	// ****************
	// bus tasks
	// ****************
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK(nm, e, d)
	endtask : chk_rd
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// bounded: a stuck time base must not hang the run
	task automatic wait_trig;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (gen_trig[0] !== 1'b1 && n < 60);
		if (n >= 60) begin
			mismatches++;
			print_verdict;
		end
	endtask : wait_trig
	// ****************
	// main sequence
	// ****************
	initial begin
		seed = 91056;
		{reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, cmp_evt, fault_pin, pwm_raw} = '0;
		{mismatches, num_checks, intc_en, rnd_raw} = '0;
		rnd_raw = 1'b1;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		chk_rd("fsel", 8'h1C, 32'h1111);
		chk_rd("ctrl", 8'h00, 32'h0);
		chk_rd("unmapped", 8'h3C, 32'h0);
		$display("test reset done");
		wr(8'h04, 32'hFF);
		for (int g = 0; g < 4; g++) for (int e = 2; e < 6; e++) begin
			ga = {2'h1, g[1:0], 4'h0};
			en = (g == 0) ? 6'h00 : 6'($random(seed));
			intc_en <= {1'b0, 4'(e % 2) << g};
			wr(ga, {18'h0, ~en, 2'h0, en});
			@(posedge clk) cmp_evt <= 16'h1 << (4 * g + e - 2);
			@(posedge clk) cmp_evt <= 16'h0;
			#1 `CHK("trig early", 1'b0, gen_trig[g])
			@(posedge clk);
			#1 `CHK("trig", ~en[e], gen_trig[g])
			`CHK("girq", en[e], gen_irq[g])
			`CHK("cpu", en[e] & 1'(e % 2), cpu_irq)
			chk_rd("ris", ga + 8'h4, 32'h1 << e);
			chk_rd("isc", ga + 8'h8, 32'(en[e]) << e);
			wr(ga + 8'h8, 32'h0);
			chk_rd("ris keep", ga + 8'h4, 32'h1 << e);
			wr(ga + 8'h8, 32'h3F);
			chk_rd("ris clr", ga + 8'h4, 32'h0);
		end
		$display("test events done");
		wr(8'h50, 32'h3F);
		@(posedge clk) cmp_evt <= 16'h0010;
		@(posedge clk) cmp_evt <= 16'h0;
		wr(8'h04, 32'h0);
		repeat (2) @(posedge clk);
		#1 `CHK("mask", 5'h00, {irq, gen_irq})
		chk_rd("mris", 8'h08, 32'h02);
		wr(8'h04, 32'hFF);
		intc_en <= 5'h10;
		repeat (2) @(posedge clk);
		#1 `CHK("unmask", 5'h12, {irq, gen_irq})
		`CHK("cpu mod", 1'b1, cpu_irq)
		wr(8'h58, 32'h3F);
		$display("test module mask done");
		rnd_raw = 1'b0;
		pwm_raw <= 8'hFF;
		wr(8'h10, 32'h55);
		fault_pin <= 4'h1;
		repeat (4) @(posedge clk);
		#1 `CHK("suppress", 8'hAA, pwm_out)
		chk_rd("mris flt", 8'h08, 32'h10);
		pwm_raw <= 8'h00;
		wr(8'h14, 32'h04);
		wr(8'h00, 32'h20);
		wr(8'h18, 32'h02);
		wr(8'h1C, 32'h1121);
		fault_pin <= 4'h0;
		repeat (4) @(posedge clk);
		#1 `CHK("level", 8'h04, pwm_out)
		wr(8'h18, 32'h00);
		repeat (4) @(posedge clk);
		#1 `CHK("sense", 8'h00, pwm_out)
		wr(8'h0C, 32'hF0);
		chk_rd("mris clr", 8'h08, 32'h0);
		rnd_raw = 1'b1;
		$display("test faults done");
		wr(8'h40, 32'h100);
		wr(8'h4C, 32'h7);
		wr(8'h4C, 32'h5);
		chk_rd("per", 8'h4C, 32'h5);
		wr(8'h00, 32'h1);
		wait_trig;
		wait_trig;
		`CHK("gap", 5, n)
		wr(8'h4C, 32'h9);
		chk_rd("per new", 8'h4C, 32'h9);
		wait_trig;
		wait_trig;
		`CHK("gap new", 9, n)
		$display("test period done");
		print_verdict;
	end
endmodule : pwmifc_top_tb
